/* hdl/mamd_consts.svh */
`ifndef MAMD_CONSTS_SVH
`define MAMD_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MAMD_OFF_SHADOW0 12'h000
`define MAMD_OFF_SHADOW1 12'h004
`define MAMD_OFF_SHADOW2 12'h008
`define MAMD_OFF_SHADOW3 12'h00C
`define MAMD_OFF_HOLE_BASE 12'h010
`define MAMD_OFF_HOLE_SIZE 12'h014
`define MAMD_OFF_CONFIG 12'h018
`define MAMD_OFF_DEC_REQ 12'h01C
`define MAMD_OFF_DEC_RES 12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MAMD_CFG_VGA_EN 0
`define MAMD_CFG_VGA_FULL 1
`define MAMD_CFG_HOLE_EN 2
`define MAMD_CFG_BANKSZ_LO 4
`define MAMD_S3_CACHE_LO 0
`define MAMD_S3_ROM_LO 4
`define MAMD_S3_F_RD 8
`define MAMD_S3_F_WR 9
`define MAMD_S3_F_CACHE 10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MAMD_RST_SHADOW 32'h0000_0000
`define MAMD_RST_CONFIG 32'h0000_0001
`define MAMD_RST_HOLE 32'h0000_0000

// ----------------------------------------------------------------
// Address map boundaries (in 16K units, address bits 31:14), ISA address mask, bank count and memory size limits in MB
// ----------------------------------------------------------------
`define MAMD_SEG_VGA_LO 18'h00028
`define MAMD_SEG_C0 18'h00030
`define MAMD_SEG_D0 18'h00034
`define MAMD_SEG_E0 18'h00038
`define MAMD_SEG_F0 18'h0003C
`define MAMD_SEG_1M 18'h00040
`define MAMD_SEG_16M 18'h00400
`define MAMD_MB_PER_16K 18'h00040
`define MAMD_ISA_MASK 32'h00FF_FFFF
`define MAMD_NUM_BANKS 4
`define MAMD_MIN_MB 8'd2
`define MAMD_MAX_MB 8'd128

`endif

/* hdl/mamd_pkg.sv */
package mamd_pkg;
  typedef enum logic [1:0] {
    MAMD_HOST = 2'b00,
    MAMD_PCI = 2'b01,
    MAMD_ISA = 2'b10,
    MAMD_DMA = 2'b11
  } mamd_master_e;

  typedef enum logic [1:0] {
    MAMD_DST_MEM = 2'b00,
    MAMD_DST_PCI = 2'b01,
    MAMD_DST_PCI_ISA = 2'b10,
    MAMD_DST_ISA = 2'b11
  } mamd_dest_e;

  typedef enum logic [1:0] {
    MAMD_BK_1M = 2'b00,
    MAMD_BK_2M = 2'b01,
    MAMD_BK_4M = 2'b10,
    MAMD_BK_NONE = 2'b11
  } mamd_bank_e;
endpackage

/* hdl/mamd_decoder.sv */
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "mamd_consts.svh"

module mamd_decoder #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Cycle decode request
  input wire logic cyc_valid_i,
  input wire logic [ADDR_W-1:0] cyc_addr_i,
  input wire mamd_pkg::mamd_master_e cyc_master_i,
  input wire logic cyc_write_i,
  input wire logic pci_claimed_i,
  input wire logic pci_subdec_i,
  input wire logic mem_busy_i,
  // Decode results
  output logic dec_valid_o,
  output mamd_pkg::mamd_dest_e dec_dest_o,
  output logic dec_cacheable_o,
  output logic rom_select_n_o,
  output logic [23:0] isa_addr_o,
  output logic mem_start_o,
  output logic [3:0] bank_select_n_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic isa_ready_o,
  output logic isa_data_oe_o
);
  import mamd_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] shadow_ff [4];
  logic [31:0] nxt_shadow [4];
  logic [31:0] hole_base_ff, nxt_hole_base;
  logic [31:0] hole_size_ff, nxt_hole_size;
  logic [31:0] config_ff, nxt_config;
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic wr_go;
  logic [31:0] res_word;

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_go = aw_ff && w_ff;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_shadow = shadow_ff;
    nxt_hole_base = hole_base_ff;
    nxt_hole_size = hole_size_ff;
    nxt_config = config_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = 2'b00;
      case ({awaddr_ff[11:2], 2'b00})
        `MAMD_OFF_SHADOW0: nxt_shadow[0] =
          merge(shadow_ff[0], wdata_ff, wstrb_ff);
        `MAMD_OFF_SHADOW1: nxt_shadow[1] =
          merge(shadow_ff[1], wdata_ff, wstrb_ff);
        `MAMD_OFF_SHADOW2: nxt_shadow[2] =
          merge(shadow_ff[2], wdata_ff, wstrb_ff);
        `MAMD_OFF_SHADOW3: nxt_shadow[3] =
          merge(shadow_ff[3], wdata_ff, wstrb_ff);
        `MAMD_OFF_HOLE_BASE: nxt_hole_base =
          merge(hole_base_ff, wdata_ff, wstrb_ff);
        `MAMD_OFF_HOLE_SIZE: nxt_hole_size =
          merge(hole_size_ff, wdata_ff, wstrb_ff);
        `MAMD_OFF_CONFIG: nxt_config =
          merge(config_ff, wdata_ff, wstrb_ff);
        `MAMD_OFF_DEC_RES: nxt_bresp = 2'b10;
        default: nxt_bresp = 2'b10;
      endcase
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = 2'b00;
      case ({s_axi_araddr[11:2], 2'b00})
        `MAMD_OFF_SHADOW0: nxt_rdata = shadow_ff[0];
        `MAMD_OFF_SHADOW1: nxt_rdata = shadow_ff[1];
        `MAMD_OFF_SHADOW2: nxt_rdata = shadow_ff[2];
        `MAMD_OFF_SHADOW3: nxt_rdata = shadow_ff[3];
        `MAMD_OFF_HOLE_BASE: nxt_rdata = hole_base_ff;
        `MAMD_OFF_HOLE_SIZE: nxt_rdata = hole_size_ff;
        `MAMD_OFF_CONFIG: nxt_rdata = config_ff;
        `MAMD_OFF_DEC_RES: nxt_rdata = res_word;
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        shadow_ff[i] <= `MAMD_RST_SHADOW;
      end
      hole_base_ff <= `MAMD_RST_HOLE;
      hole_size_ff <= `MAMD_RST_HOLE;
      config_ff <= `MAMD_RST_CONFIG;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      shadow_ff <= nxt_shadow;
      hole_base_ff <= nxt_hole_base;
      hole_size_ff <= nxt_hole_size;
      config_ff <= nxt_config;
    end
  end

  // ----------------------------------------------------------------
  // Memory size and hole limits
  // ----------------------------------------------------------------
  mamd_bank_e bank_sz;
  logic [7:0] bank_mb;
  logic [7:0] total_mb;
  logic [17:0] top_seg;
  logic [17:0] hole_lo, hole_hi;
  logic hole_on;

  assign bank_sz = mamd_bank_e'(config_ff[`MAMD_CFG_BANKSZ_LO +: 2]);

  always_comb begin
    case (bank_sz)
      MAMD_BK_1M: bank_mb = 8'd8;
      MAMD_BK_2M: bank_mb = 8'd16;
      MAMD_BK_4M: bank_mb = 8'd32;
      default: bank_mb = 8'd0;
    endcase
  end

  // Four banks of bank_mb, clamped to the supported range
  always_comb begin
    total_mb = bank_mb << 2;
    if (total_mb > `MAMD_MAX_MB) begin
      total_mb = `MAMD_MAX_MB;
    end
    if (total_mb < `MAMD_MIN_MB) begin
      total_mb = `MAMD_MIN_MB;
    end
  end

  assign top_seg = 18'({10'h000, total_mb} * `MAMD_MB_PER_16K);

  // Hole bounds in 16K units, confined to 1M..16M
  always_comb begin
    hole_lo = hole_base_ff[31:14];
    hole_hi = 18'(hole_base_ff[31:14] + hole_size_ff[31:14]);
    hole_on = config_ff[`MAMD_CFG_HOLE_EN] &&
              hole_lo >= `MAMD_SEG_1M && hole_hi <= `MAMD_SEG_16M &&
              hole_hi > hole_lo;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [17:0] seg;
  logic [1:0] sub;
  logic shadowed;
  logic rom_en;
  mamd_dest_e fwd_dest;
  mamd_dest_e dest;
  logic cache;
  logic rom;
  logic to_mem;

  assign seg = cyc_addr_i[31:14];
  assign sub = cyc_addr_i[15:14];

  // Forwarding path for cycles that do not hit memory
  always_comb begin
    case (cyc_master_i)
      MAMD_HOST: fwd_dest = MAMD_DST_PCI_ISA;
      MAMD_PCI: fwd_dest = MAMD_DST_ISA;
      default: fwd_dest = MAMD_DST_PCI;
    endcase
  end

  always_comb begin
    shadowed = 1'b0;
    rom_en = 1'b0;
    cache = 1'b0;
    to_mem = 1'b0;
    if (seg < `MAMD_SEG_VGA_LO) begin
      to_mem = 1'b1;
      cache = 1'b1;
    end else if (seg < `MAMD_SEG_C0) begin
      to_mem = config_ff[`MAMD_CFG_VGA_EN] &&
               config_ff[`MAMD_CFG_VGA_FULL];
      cache = 1'b0;
    end else if (seg < `MAMD_SEG_D0) begin
      // Two bits per 16K segment: read enable, write enable
      shadowed = shadow_ff[0][{sub, cyc_write_i}];
      to_mem = shadowed;
      rom_en = shadow_ff[3][`MAMD_S3_ROM_LO + 32'(sub)];
      cache = shadowed && !sub[1] &&
              shadow_ff[3][`MAMD_S3_CACHE_LO + 32'(sub)];
    end else if (seg < `MAMD_SEG_E0) begin
      shadowed = shadow_ff[1][{sub, cyc_write_i}];
      to_mem = shadowed;
      rom_en = shadow_ff[3][`MAMD_S3_ROM_LO + 2];
    end else if (seg < `MAMD_SEG_F0) begin
      shadowed = shadow_ff[2][{sub, cyc_write_i}];
      to_mem = shadowed;
      rom_en = shadow_ff[3][`MAMD_S3_ROM_LO + 3];
    end else if (seg < `MAMD_SEG_1M) begin
      shadowed = cyc_write_i ? shadow_ff[3][`MAMD_S3_F_WR]
                             : shadow_ff[3][`MAMD_S3_F_RD];
      to_mem = shadowed;
      rom_en = 1'b1;
      cache = shadowed && shadow_ff[3][`MAMD_S3_F_CACHE];
    end else if (seg < top_seg &&
                 !(hole_on && seg >= hole_lo && seg < hole_hi)) begin
      to_mem = 1'b1;
      cache = 1'b1;
    end
  end

  // Final routing per master and direction
  always_comb begin
    dest = to_mem ? MAMD_DST_MEM : fwd_dest;
    rom = !to_mem && rom_en &&
          (dest == MAMD_DST_ISA || dest == MAMD_DST_PCI_ISA);
    if (!to_mem && seg >= `MAMD_SEG_VGA_LO && seg < `MAMD_SEG_C0 &&
        cyc_master_i == MAMD_PCI) begin
      dest = MAMD_DST_ISA;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic dec_valid_ff;
  mamd_dest_e dest_ff;
  logic cache_ff, rom_ff, start_ff, oe_ff, ready_ff;
  logic [3:0] bank_n_ff;
  logic [ADDR_W-1:0] mem_addr_ff;
  logic [23:0] isa_addr_ff;
  logic mem_req;
  logic [1:0] bank_idx;

  // PCI masters only reach memory after the subtractive point
  assign mem_req = cyc_valid_i && to_mem &&
                   (cyc_master_i != MAMD_PCI ||
                    (pci_subdec_i && !pci_claimed_i));
  // No bank size programmed: keep the index defined instead of dividing by 0
  assign bank_idx = (bank_mb == 8'd0) ? 2'b00 :
                    2'(cyc_addr_i[ADDR_W-1:20] / 32'(bank_mb));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_ff <= 1'b0;
      dest_ff <= MAMD_DST_MEM;
      cache_ff <= 1'b0;
      rom_ff <= 1'b0;
      start_ff <= 1'b0;
      bank_n_ff <= 4'hF;
      mem_addr_ff <= '0;
      isa_addr_ff <= 24'h00_0000;
      oe_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else begin
      dec_valid_ff <= cyc_valid_i;
      dest_ff <= dest;
      cache_ff <= cache;
      rom_ff <= cyc_valid_i && rom;
      start_ff <= mem_req;
      bank_n_ff <= mem_req ? ~(4'h1 << bank_idx) : 4'hF;
      mem_addr_ff <= cyc_addr_i;
      isa_addr_ff <= 24'(cyc_addr_i & `MAMD_ISA_MASK);
      oe_ff <= mem_req && cyc_master_i == MAMD_DMA &&
               !cyc_write_i;
      ready_ff <= !(cyc_valid_i && to_mem &&
                    cyc_master_i == MAMD_ISA && mem_busy_i);
    end
  end

  assign res_word = {20'h00000, ready_ff, oe_ff, start_ff, rom_ff,
                     cache_ff, 1'b0, dest_ff, bank_n_ff};
  assign dec_valid_o = dec_valid_ff;
  assign dec_dest_o = dest_ff;
  assign dec_cacheable_o = cache_ff;
  assign rom_select_n_o = !rom_ff;
  assign isa_addr_o = isa_addr_ff;
  assign mem_start_o = start_ff;
  assign bank_select_n_o = bank_n_ff;
  assign mem_addr_o = mem_addr_ff;
  assign isa_ready_o = ready_ff;
  assign isa_data_oe_o = oe_ff;
  // check bits and memory type are outside this decode path
endmodule

/* testbench/mamd_decoder_assertions.sv */
`timescale 1ns/100ps
module mamd_decoder_assertions
  import mamd_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_valid_i,
  input wire logic [ADDR_W-1:0] cyc_addr_i,
  input wire mamd_pkg::mamd_master_e cyc_master_i,
  input wire logic cyc_write_i,
  input wire logic pci_claimed_i,
  input wire logic pci_subdec_i,
  input wire logic mem_busy_i,
  input wire logic dec_valid_o,
  input wire mamd_pkg::mamd_dest_e dec_dest_o,
  input wire logic dec_cacheable_o,
  input wire logic rom_select_n_o,
  input wire logic [23:0] isa_addr_o,
  input wire logic mem_start_o,
  input wire logic [3:0] bank_select_n_o,
  input wire logic isa_ready_o,
  input wire logic isa_data_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic lo, vid, nc, fs;
  assign lo = cyc_valid_i && cyc_addr_i < 32'h000A_0000;
  assign vid = cyc_valid_i && cyc_addr_i[31:17] == 15'h0005;
  assign nc = cyc_valid_i && cyc_addr_i >= 32'h000C_8000
    && cyc_addr_i < 32'h000F_0000;
  assign fs = cyc_valid_i && cyc_addr_i[31:16] == 16'h000F;
  property p_valid;
    cyc_valid_i |=> dec_valid_o;
  endproperty
  a_valid: assert property (p_valid)
    else $error("decode result missing");
  property p_host_low;
    lo && cyc_master_i == MAMD_HOST |=> dec_dest_o == MAMD_DST_MEM
      && mem_start_o && dec_cacheable_o;
  endproperty
  a_host_low: assert property (p_host_low)
    else $error("host low cycle not to memory");
  property p_pci_low;
    lo && cyc_master_i == MAMD_PCI
      |=> mem_start_o == $past(pci_subdec_i && !pci_claimed_i);
  endproperty
  a_pci_low: assert property (p_pci_low)
    else $error("pci low start wrong");
  property p_isa_busy;
    lo && cyc_master_i == MAMD_ISA && mem_busy_i |=> !isa_ready_o;
  endproperty
  a_isa_busy: assert property (p_isa_busy)
    else $error("isa cycle not stretched");
  property p_dma_rd;
    lo && cyc_master_i == MAMD_DMA && !cyc_write_i |=> isa_data_oe_o;
  endproperty
  a_dma_rd: assert property (p_dma_rd)
    else $error("dma read data not driven");
  property p_vid_nc;
    vid |=> !dec_cacheable_o;
  endproperty
  a_vid_nc: assert property (p_vid_nc)
    else $error("video window cacheable");
  property p_rom_nc;
    nc |=> !dec_cacheable_o;
  endproperty
  a_rom_nc: assert property (p_rom_nc)
    else $error("hardwired segment cacheable");
  property p_f_rom;
    fs ##1 (dec_dest_o == MAMD_DST_ISA || dec_dest_o == MAMD_DST_PCI_ISA)
      |-> !rom_select_n_o;
  endproperty
  a_f_rom: assert property (p_f_rom)
    else $error("top segment rom select missing");
  property p_alias;
    cyc_valid_i |=> isa_addr_o == $past(cyc_addr_i[23:0]);
  endproperty
  a_alias: assert property (p_alias)
    else $error("isa address not aliased");
  property p_bank;
    mem_start_o |-> $onehot(~bank_select_n_o);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select not one hot");
endmodule

bind mamd_decoder mamd_decoder_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i, .rst_i, .cyc_valid_i, .cyc_addr_i, .cyc_master_i, .cyc_write_i,
  .pci_claimed_i, .pci_subdec_i, .mem_busy_i, .dec_valid_o, .dec_dest_o,
  .dec_cacheable_o, .rom_select_n_o, .isa_addr_o, .mem_start_o,
  .bank_select_n_o, .isa_ready_o, .isa_data_oe_o);

/* testbench/mamd_far_model.sv */
`timescale 1ns/100ps
module mamd_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic claim_en_i,
  input wire logic busy_en_i,
  output logic pci_claimed_o,
  output logic pci_subdec_o,
  output logic mem_busy_o
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 2'h0;
      pci_claimed_o <= 1'h0;
      pci_subdec_o <= 1'h0;
      mem_busy_o <= 1'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      // Slow bus: decode point only every fourth cycle
      pci_subdec_o <= cnt_ff == 2'h3;
      pci_claimed_o <= claim_en_i;
      // Burst-capable memory, busy on alternate cycles when enabled
      mem_busy_o <= busy_en_i && cnt_ff[0];
    end
  end
endmodule

/* testbench/memory_address_map_decoder_tb_top.sv */
`timescale 1ns/100ps
module memory_address_map_decoder_tb_top;
  import mamd_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, ca = 0, rdata, cfg, hb, hs, maddr;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cv = 0, cw = 0, claim_en = 0, busy_en = 0;
  logic claimed, subdec, busy, dv, dc, rn, ms, ir, oe;
  mamd_master_e cm = MAMD_HOST;
  mamd_dest_e dd;
  logic [23:0] ia;
  logic [3:0] bn;
  logic [31:0] sh [4];
  int err_total = 0, total_checks = 0, cyc = 0;

  mamd_decoder uut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cyc_valid_i(cv),
    .cyc_addr_i(ca), .cyc_master_i(cm), .cyc_write_i(cw),
    .pci_claimed_i(claimed), .pci_subdec_i(subdec), .mem_busy_i(busy),
    .dec_valid_o(dv), .dec_dest_o(dd), .dec_cacheable_o(dc),
    .rom_select_n_o(rn), .isa_addr_o(ia), .mem_start_o(ms),
    .bank_select_n_o(bn), .mem_addr_o(maddr), .isa_ready_o(ir),
    .isa_data_oe_o(oe));
  mamd_far_model far (.clk_i(clk_i), .rst_i(rst_i), .claim_en_i(claim_en),
    .busy_en_i(busy_en), .pci_claimed_o(claimed), .pci_subdec_o(subdec),
    .mem_busy_o(busy));

  initial forever #10 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 0;
    while (!tb) begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 0;
    while (!tr) begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge clk_i);
  endtask

  function automatic logic [31:0] pick();
    int t;
    t = (cfg[5:4] == 2'h3 ? 2 : 32 << cfg[5:4]) << 20;
    case ($urandom % 6)
      0: pick = $urandom % 32'h000A_0000;
      1: pick = 32'h000A_0000 + $urandom % 32'h0005_0000;
      2: pick = 32'h000F_0000 + $urandom % 32'h0001_0000;
      3: pick = 32'h0010_0000 + $urandom % t;
      4: pick = hb + $urandom % (hs + 1);
      default: pick = $urandom;
    endcase
  endfunction

  // One decode request, compared with the reference model
  task automatic dec(input logic [31:0] a, input mamd_master_e m,
                     input logic w);
    int i, bk, er;
    logic s, mp, ec, es, b;
    mamd_dest_e ed;
    ca <= a;
    cm <= m;
    cw <= w;
    cv <= 1'h1;
    @(negedge clk_i);
    s = subdec && !claimed;
    b = busy;
    @(posedge clk_i);
    @(negedge clk_i);
    bk = cfg[5:4] == 2'h3 ? 0 : 8 << cfg[5:4];
    ec = 0;
    er = 1;
    mp = 1;
    if (a < 32'h000A_0000) ec = 1;
    else if (a < 32'h000C_0000) mp = cfg[0] && cfg[1];
    else if (a < 32'h000F_0000) begin
      i = (a >> 14) - 32'h30;
      mp = sh[i / 4][2 * (i % 4) + w];
      ec = i < 2 && mp && sh[3][i];
      er = i < 2 ? !sh[3][4 + i] : i < 4 ? -1 : !sh[3][5 + i / 4];
    end else if (a < 32'h0010_0000) begin
      mp = sh[3][8 + w];
      ec = mp && sh[3][10];
      er = 0;
    end else begin
      mp = !(cfg[2] && a >= hb && a < hb + hs)
        && a < ((bk == 0 ? 2 : 4 * bk) << 20);
      ec = mp;
    end
    ed = mp ? MAMD_DST_MEM : m == MAMD_HOST ? MAMD_DST_PCI_ISA
      : m == MAMD_PCI ? MAMD_DST_ISA : MAMD_DST_PCI;
    es = mp && (m != MAMD_PCI || s);
    chk(dv, 1);
    chk(ia, a[23:0]);
    chk(dc, ec);
    chk(maddr, a);
    chk(dd, ed);
    chk(ms, es);
    chk(ir, !(mp && m == MAMD_ISA && b));
    chk(oe, es && m == MAMD_DMA && !w);
    if (!mp && m == MAMD_PCI && er >= 0) chk(rn, er);
    if (es && bk > 0) chk(bn, 4'(~(4'h1 << ((a >> 20) / bk))));
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int k, j;
    k = $urandom(78230);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    cfg = 32'h0000_0001;
    hb = 0;
    hs = 0;
    for (k = 0; k < 8; k++) begin
      axi_rd(k == 7 ? 12'h024 : 12'(k * 4), d, r);
      chk(d, k == 6 ? 1 : 0);
      chk(r, k == 7 ? 2 : 0);
    end
    axi_wr(12'h024, 32'h0000_00FF, r);
    chk(r, 2);
    for (j = 0; j < 24; j++) begin
      for (k = 0; k < 4; k++) begin
        sh[k] = $urandom;
        axi_wr(12'(k * 4), sh[k], r);
        chk(r, 0);
      end
      cfg = ((j % 4) << 4) | ($urandom & 7);
      hb = 32'h0010_0000 + (($urandom % 64) << 14);
      hs = ($urandom % 128) << 14;
      axi_wr(12'h010, hb, r);
      axi_wr(12'h014, hs, r);
      axi_wr(12'h018, cfg, r);
      for (k = 0; k < 40; k++) begin
        claim_en <= 1'($urandom);
        busy_en <= 1'($urandom);
        dec(pick(), mamd_master_e'(2'($urandom)), 1'($urandom));
      end
    end
    give_verdict();
  end
endmodule
